// file: inc/pci_defs.svh
`ifndef PCI_DEFS_SVH
`define PCI_DEFS_SVH
// Behaviour
// [R1] While sleeping, an enabled flagged edge wakes the core only with master enable set.
// [R2] Edge seen in sleep is already in the flag register before wake completes.
// [R3] Rising enable bit per pin arms low-to-high detection; clear ignores rises.
// [R4] Falling enable bit per pin arms high-to-low detection; both give either edge.
// [R5] Flag sets on enabled rising edge or enabled falling edge of its pin.
// [R6] Flag stays set until software writes zero to it.
// [R7] Rise, fall and flag registers reset to zero on every reset.
// [R8] Summary flag is the OR of all eight pin flags.
// [R9] Detection and flagging continue with master enable clear; only request is gated.
// [R10] Edge during a clearing write leaves its flag set whatever was written.
// [R11] Pins are synchronised, compared with previous sample, one set pulse per edge.

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PCI_OFF_RISE    12'h000
`define PCI_OFF_FALL    12'h004
`define PCI_OFF_FLAGS   12'h008
`define PCI_OFF_CTRL    12'h00C
`define PCI_OFF_IRQ_ST  12'h010
`define PCI_OFF_IRQ_MSK 12'h014
`define PCI_ADDR_W      12

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PCI_CTRL_MEN_BIT 0
`define PCI_ST_EDGE_BIT  0
`define PCI_ST_WAKE_BIT  1
`define PCI_REG8_RST     8'h00
`define PCI_REG2_RST     2'h0
`define PCI_HTRANS_NSEQ  2'h2

// ----------------------------------------
// Edge detector arming
// ----------------------------------------
// Edges ignored until prev holds a real pin sample after reset
`define PCI_ARM_W        3
`define PCI_HSIZE_WORD   3'h2
`endif

// file: inc/pci_pkg.sv
package pci_pkg;
  // Bus slave phase
  typedef enum logic [0:0] {
    PCI_IDLE = 1'b0,
    PCI_DATA = 1'b1
  } pci_phase_t;

  // State of the top module except the sleep synchroniser flops
  typedef struct packed {
    pci_phase_t phase;
    logic       wr;
    logic [11:0] addr;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] flags;
    logic       men;
    logic [1:0] irq_st;
    logic [1:0] irq_msk;
    logic [31:0] rdata;
    logic       wake;
  } pci_state_t;
endpackage

// file: inc/pci_edge_if.sv
`timescale 1ns/1ns
// Edge pulses from the detector to the register core
interface pci_edge_if;
  logic [7:0] rise_evt;
  logic [7:0] fall_evt;
  modport det (output rise_evt, output fall_evt);
  modport core (input rise_evt, input fall_evt);
endinterface // pci_edge_if

// file: rtl/pci_edge_det.sv
`timescale 1ns/1ns
`include "pci_defs.svh"
// Two-stage synchroniser plus edge compare for eight pins
module pci_edge_det (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Pins
  input  wire logic [7:0] pins_i,
  // Edge pulses
  pci_edge_if.det         edge_o
);
  logic [7:0] meta_r;
  logic [7:0] sync_r;
  logic [7:0] prev_r;
  logic [`PCI_ARM_W-1:0] arm_r;

  // Only sync_r reads meta_r; prev_r holds last sample
  // [R11] sync and compare
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= `PCI_REG8_RST;
      sync_r <= `PCI_REG8_RST;
      prev_r <= `PCI_REG8_RST;
      arm_r  <= '0;
    end else begin
      meta_r <= pins_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
      arm_r  <= {arm_r[`PCI_ARM_W-2:0], 1'b1};
    end
  end

  // One-cycle pulses per transition; a pin held high through reset
  // would otherwise look like a rise against the zeroed prev_r
  assign edge_o.rise_evt = (sync_r & ~prev_r) & {8{arm_r[`PCI_ARM_W-1]}};
  assign edge_o.fall_evt = (~sync_r & prev_r) & {8{arm_r[`PCI_ARM_W-1]}};

  // [R11] one pulse per edge
  a_rise_pulse_once : assert property (@(posedge clk_i) disable iff (rst_i)
    (edge_o.rise_evt != 8'h00) |=> ((edge_o.rise_evt & $past(edge_o.rise_evt)) == 8'h00))
    else $error("rise pulse lasted two cycles");
endmodule // pci_edge_det

// file: rtl/pci_top.sv
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ns
`include "pci_defs.svh"
// Pin change interrupt block with AHB-Lite register slave
module pci_top (
  // Clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_I,
  // AHB-Lite slave
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  // Port pins and core
  input  wire logic [7:0]  PORT_TWO_PIN_I,
  input  wire logic        CORE_SLEEP_I,
  // Requests
  output logic             CHANGE_IRQ_SUMMARY_FLAG_O,
  output logic             CHANGE_IRQ_O,
  output logic             CORE_WAKE_O,
  output logic             IRQ_O
);
  pci_pkg::pci_state_t s_r;
  pci_pkg::pci_state_t s_nxt;
  logic                sleep_meta_r;
  logic                sleep_sync_r;
  logic                take;
  logic [7:0]          set_mask;
  logic [7:0]          wr_byte;
  logic                summary;
  logic                wake_evt;

  pci_edge_if edge_bus ();

  // ----------------------------------------
  // Pin edge detection
  // ----------------------------------------
  pci_edge_det u_det (
    .clk_i  (CLK_SYS_I),
    .rst_i  (RST_I),
    .pins_i (PORT_TWO_PIN_I),
    .edge_o (edge_bus.det)
  );

  // Sleep status comes from another block; synchronise it
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      sleep_meta_r <= 1'b0;
      sleep_sync_r <= 1'b0;
    end else begin
      sleep_meta_r <= CORE_SLEEP_I;
      sleep_sync_r <= sleep_meta_r;
    end
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Address phase accepted only for a selected NONSEQ
  assign take     = HSEL_I & HREADY_I & (HTRANS_I == `PCI_HTRANS_NSEQ);
  // [R3] [R4] [R5] enabled edges only
  assign set_mask = (edge_bus.rise_evt & s_r.rise) | (edge_bus.fall_evt & s_r.fall);
  assign wr_byte  = HWDATA_I[7:0];
  // [R8] OR of pin flags
  assign summary  = |s_r.flags;
  // Wake event: sleeping core with pending request
  assign wake_evt = sleep_sync_r & summary & s_r.men;

  always_comb begin
    s_nxt = s_r;
    s_nxt.wake = 1'b0;
    if (take) begin
      s_nxt.phase = pci_pkg::PCI_DATA;
      s_nxt.wr    = HWRITE_I;
      s_nxt.addr  = HADDR_I[`PCI_ADDR_W-1:0];
    end else if (HREADY_I) begin
      s_nxt.phase = pci_pkg::PCI_IDLE;
      s_nxt.wr    = 1'b0;
    end
    // Data phase writes
    if (s_r.phase == pci_pkg::PCI_DATA && s_r.wr) begin
      case (s_r.addr)
        `PCI_OFF_RISE:    s_nxt.rise = wr_byte;
        `PCI_OFF_FALL:    s_nxt.fall = wr_byte;
        // [R6] software clears by writing zero
        `PCI_OFF_FLAGS:   s_nxt.flags = s_r.flags & wr_byte;
        `PCI_OFF_CTRL:    s_nxt.men = wr_byte[`PCI_CTRL_MEN_BIT];
        `PCI_OFF_IRQ_ST:  s_nxt.irq_st = s_r.irq_st & ~wr_byte[1:0];
        `PCI_OFF_IRQ_MSK: s_nxt.irq_msk = wr_byte[1:0];
        default:          s_nxt.phase = s_nxt.phase;
      endcase
    end
    // [R10] [R9] [R2] set wins over clear, regardless of master enable
    s_nxt.flags = s_nxt.flags | set_mask;
    // Sticky events, set wins over write-one-to-clear
    if (set_mask != 8'h00) begin
      s_nxt.irq_st[`PCI_ST_EDGE_BIT] = 1'b1;
    end
    // [R1] wake only with master enable
    if (wake_evt) begin
      s_nxt.irq_st[`PCI_ST_WAKE_BIT] = 1'b1;
      s_nxt.wake = 1'b1;
    end
    // Read data from the state after this edge, so a back-to-back
    // write landing at the same edge is not read stale
    if (take && !HWRITE_I) begin
      case (HADDR_I[`PCI_ADDR_W-1:0])
        `PCI_OFF_RISE:    s_nxt.rdata = {24'h00_0000, s_nxt.rise};
        `PCI_OFF_FALL:    s_nxt.rdata = {24'h00_0000, s_nxt.fall};
        `PCI_OFF_FLAGS:   s_nxt.rdata = {24'h00_0000, s_nxt.flags};
        `PCI_OFF_CTRL:    s_nxt.rdata = {30'h0000_0000, |s_nxt.flags, s_nxt.men};
        `PCI_OFF_IRQ_ST:  s_nxt.rdata = {30'h0000_0000, s_nxt.irq_st};
        `PCI_OFF_IRQ_MSK: s_nxt.rdata = {30'h0000_0000, s_nxt.irq_msk};
        default:          s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // [R7] all registers to zero
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Slave never stalls: zero wait states
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = s_r.rdata;
  assign CHANGE_IRQ_SUMMARY_FLAG_O = summary;
  // [R9] only the request is gated
  assign CHANGE_IRQ_O = summary & s_r.men;
  assign CORE_WAKE_O  = s_r.wake;
  assign IRQ_O        = |(s_r.irq_st & s_r.irq_msk);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_rise_sets_flag : assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R3]
    (edge_bus.rise_evt[0] && s_r.rise[0]) |=> s_r.flags[0])
    else $error("enabled rise did not set flag");
  a_fall_sets_flag : assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R4]
    (edge_bus.fall_evt[3] && s_r.fall[3]) |=> s_r.flags[3])
    else $error("enabled fall did not set flag");
  a_no_spurious_set : assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R5]
    (!s_r.flags[5] && set_mask[5] == 1'b0) |=> !s_r.flags[5])
    else $error("flag set without enabled edge");
  a_flag_sticky : assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R6]
    (s_r.flags[2] && !(s_r.phase == pci_pkg::PCI_DATA && s_r.wr)) |=> s_r.flags[2])
    else $error("flag dropped without write");
  a_set_beats_clear : assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R10]
    (set_mask[0] && s_r.phase == pci_pkg::PCI_DATA && s_r.wr
      && s_r.addr == `PCI_OFF_FLAGS) |=> s_r.flags[0])
    else $error("edge lost during clear");
  a_summary_or : assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R8]
    CHANGE_IRQ_SUMMARY_FLAG_O == (s_r.flags != 8'h00))
    else $error("summary flag not OR of flags");
  a_gate_request : assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R9]
    (!s_r.men && set_mask[0]) |=> (s_r.flags[0] && (s_r.men || !CHANGE_IRQ_O)))
    else $error("master enable gating wrong");
  a_wake_needs_en : assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R1]
    CORE_WAKE_O |-> ($past(s_r.men) && $past(sleep_sync_r)))
    else $error("wake without master enable");
  a_flag_before_wake : assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R2]
    $rose(CORE_WAKE_O) |-> (s_r.flags != 8'h00))
    else $error("wake before flag recorded");
  a_reset_zero : assert property (@(posedge CLK_SYS_I) // [R7]
    $fell(RST_I) |-> (s_r.rise == 8'h00 && s_r.fall == 8'h00 && s_r.flags == 8'h00))
    else $error("registers not zero after reset");
endmodule // pci_top

// file: sim/pci_pin_model.sv
`timescale 1ns/1ns
// Far side: eight port pins driven from outside the device
module pci_pin_model (
  // Levels requested by the bench
  input  wire logic [7:0] level_i,
  // Pin levels seen by the block
  output logic      [7:0] pins_o
);
  // Bench changes levels just after an edge and holds them for many cycles
  // stable levels, one edge per change
  assign pins_o = level_i;
endmodule // pci_pin_model

// file: sim/pci_top_test.sv
`timescale 1ns/1ns
`include "pci_defs.svh"
module pci_top_test;
  logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, slp = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = `PCI_HSIZE_WORD;
  logic [31:0] haddr = 0, hwdata = 0, q;
  logic [7:0]  lvl = 0;
  wire  [31:0] hrdata;
  wire  [7:0]  pins;
  wire         hrdy, hresp, sum, cirq, wake, irq;
  int          n_mismatch = 0, checks_done = 0, cyc = 0;
  always #2 clk = ~clk;
  pci_pin_model pci_pin_model_i (.level_i(lvl), .pins_o(pins));
  pci_top pci_top_i (.CLK_SYS_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
    .PORT_TWO_PIN_I(pins), .CORE_SLEEP_I(slp), .CHANGE_IRQ_SUMMARY_FLAG_O(sum),
    .CHANGE_IRQ_O(cirq), .CORE_WAKE_O(wake), .IRQ_O(irq));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic results();
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // One single word transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= `PCI_HTRANS_NSEQ;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0000_0000);
    chk(n, e, q);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(`PCI_OFF_RISE, 32'h0000_0000, "rise");
    rd(`PCI_OFF_FALL, 32'h0000_0000, "fall");
    rd(`PCI_OFF_FLAGS, 32'h0000_0000, "flags");
    rd(12'h020, 32'h0000_0000, "unmapped");
    chk("hresp", 0, hresp);
  endtask
  task automatic t_edges();
    bus(1'b1, `PCI_OFF_RISE, 32'h0000_000F);
    bus(1'b1, `PCI_OFF_FALL, 32'h0000_003C);
    lvl <= 8'hFF;
    wt(8);
    rd(`PCI_OFF_FLAGS, 32'h0000_000F, "rise flags");
    chk("summary", 1, sum);
    chk("gated req", 0, cirq);
    bus(1'b1, `PCI_OFF_FLAGS, 32'h0000_0000);
    rd(`PCI_OFF_FLAGS, 32'h0000_0000, "cleared");
    lvl <= 8'h00;
    wt(8);
    bus(1'b1, `PCI_OFF_FLAGS, 32'h0000_00FF);
    rd(`PCI_OFF_FLAGS, 32'h0000_003C, "fall flags");
  endtask
  task automatic t_irq();
    bus(1'b1, `PCI_OFF_CTRL, 32'h0000_0001);
    wt(1);
    chk("change req", 1, cirq);
    chk("irq masked", 0, irq);
    bus(1'b1, `PCI_OFF_IRQ_MSK, 32'h0000_0001);
    wt(1);
    chk("irq", 1, irq);
    rd(`PCI_OFF_IRQ_MSK, 32'h0000_0001, "irq mask");
    bus(1'b1, `PCI_OFF_IRQ_ST, 32'h0000_0001);
    wt(1);
    chk("irq cleared", 0, irq);
  endtask
  task automatic t_sleep();
    bus(1'b1, `PCI_OFF_FLAGS, 32'h0000_0000);
    slp <= 1'b1;
    wt(4);
    chk("no wake", 0, wake);
    lvl <= 8'h01;
    for (int i = 0; i < 20 && wake !== 1'b1; i++) @(posedge clk);
    chk("wake", 1, wake);
    chk("flag at wake", 1, sum);
    bus(1'b1, `PCI_OFF_CTRL, 32'h0000_0000);
    wt(4);
    chk("wake off", 0, wake);
    rd(`PCI_OFF_IRQ_ST, 32'h0000_0003, "irq status");
    rd(`PCI_OFF_CTRL, 32'h0000_0002, "ctrl");
    slp <= 1'b0;
  endtask
  // Edge lands after, at the same edge as, and before a clearing write
  task automatic t_race();
    bus(1'b1, `PCI_OFF_FALL, 32'h0000_0001);
    for (int d = 0; d < 3; d++) begin
      bus(1'b1, `PCI_OFF_FLAGS, 32'h0000_0000);
      lvl <= lvl ^ 8'h01;
      wt(d);
      bus(1'b1, `PCI_OFF_FLAGS, 32'h0000_0000);
      wt(6);
      rd(`PCI_OFF_FLAGS, (d == 2) ? 32'h0000_0000 : 32'h0000_0001, "race flag");
    end
  endtask
  // Reset in mid-run clears what software wrote
  task automatic t_rst_mid();
    bus(1'b1, `PCI_OFF_RISE, 32'h0000_00FF);
    bus(1'b1, `PCI_OFF_CTRL, 32'h0000_0001);
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    rd(`PCI_OFF_RISE, 32'h0000_0000, "rise after reset");
    rd(`PCI_OFF_CTRL, 32'h0000_0000, "ctrl after reset");
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    wt(5);
    rst <= 1'b0;
    wt(1);
    t_reset();
    t_edges();
    t_irq();
    t_sleep();
    t_race();
    t_rst_mid();
    results();
  end
endmodule // pci_top_test
